// ===== design/rcp_pkg.sv
// Package of constants for the reset-cause and power-up timer block
package rcp_pkg;

    // ----------------------------------------------------------------
    // Clock and timing
    // ----------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_PS = 4000;
    localparam int unsigned RC_PERIOD_NS = 32;
    localparam int unsigned RC_PERIOD_PS = RC_PERIOD_NS * 1000 * 1000;
    localparam int unsigned RC_TICK_CYCLES = RC_PERIOD_PS / CLK_PERIOD_PS / 1000 * 1000;
    localparam int unsigned POWER_UP_TIMER_BITS = 11;
    localparam int unsigned POWER_UP_TIMER_COUNTS = 2048;
    localparam int unsigned POWER_UP_TIMER_TOTAL_US = 65600;
    localparam int unsigned MASTER_CLEAR_N_FILT_NS = 200;
    localparam int unsigned MASTER_CLEAR_N_FILT_CYCLES = (MASTER_CLEAR_N_FILT_NS * 1000 + CLK_PERIOD_PS - 1)
        / CLK_PERIOD_PS;
    localparam int unsigned RST_HOLD_NS = 16;
    localparam int unsigned RST_HOLD_CYCLES = (RST_HOLD_NS * 1000 + CLK_PERIOD_PS - 1)
        / CLK_PERIOD_PS;
    localparam int unsigned CFG_W = 16;

    // ----------------------------------------------------------------
    // Register offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] OFS_RESET_CAUSE = 8'h00;
    localparam logic [7:0] OFS_EVT_STATUS = 8'h04;
    localparam logic [7:0] OFS_EVT_CLEAR = 8'h08;
    localparam logic [7:0] OFS_EVT_ENABLE = 8'h0c;

    // ----------------------------------------------------------------
    // Reset cause register fields
    // ----------------------------------------------------------------
    localparam int unsigned BIT_INTERRUPT_PRIORITY_ENABLE = 7;
    localparam int unsigned BIT_UNUSED = 6;
    localparam int unsigned BIT_CM = 5;
    localparam int unsigned BIT_RI = 4;
    localparam int unsigned BIT_TO = 3;
    localparam int unsigned BIT_PD = 2;
    localparam int unsigned BIT_POR = 1;
    localparam int unsigned BIT_BOR = 0;
    localparam logic [7:0] RESET_CAUSE_RST = 8'h3c;
    localparam logic [7:0] RESET_CAUSE_SW_MASK = 8'hb3;

    // ----------------------------------------------------------------
    // Event status fields
    // ----------------------------------------------------------------
    localparam int unsigned EVT_W = 6;
    localparam int unsigned EVT_POR = 0;
    localparam int unsigned EVT_BOR = 1;
    localparam int unsigned EVT_MASTER_CLEAR_N = 2;
    localparam int unsigned EVT_CM = 3;
    localparam int unsigned EVT_RI = 4;
    localparam int unsigned EVT_WDT = 5;
    localparam logic [EVT_W-1:0] EVT_RST = 6'h00;

endpackage

// ===== design/rcp_timer_if.sv
// Interface between the reset controller and its power-up timer
`timescale 1ns/10ps
interface rcp_timer_if;
    logic tick;
    logic restart;
    logic busy;
    modport timer (input tick, input restart, output busy);
    modport ctrl (output tick, output restart, input busy);
endinterface

// ===== design/rcp_glitch_filter.sv
// Pulse filter for the synchronised master-clear level
`timescale 1ns/10ps
module rcp_glitch_filter
    import rcp_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic nrst_i,
    input wire logic level_i,
    output logic level_o
);
    import rcp_pkg::*;

    logic [7:0] cnt_q;
    logic level_q;
    wire differs = level_i != level_q;
    wire settled = cnt_q == 8'(MASTER_CLEAR_N_FILT_CYCLES - 1);

    // ----------------------------------------------------------------
    // Accept a new level only after it held steady
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk_i) begin
        if (!nrst_i) begin
            cnt_q <= 8'h00;
            level_q <= 1'b1;
        end else if (!differs) begin
            cnt_q <= 8'h00;
        end else if (settled) begin
            cnt_q <= 8'h00;
            level_q <= level_i;
        end else begin
            cnt_q <= cnt_q + 8'h01;
        end
    end

    assign level_o = level_q;

endmodule // rcp_glitch_filter

// ===== design/rcp_pwrup_timer.sv
// Power-up timer counting slow oscillator ticks
`timescale 1ns/10ps
module rcp_pwrup_timer
    import rcp_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic nrst_i,
    rcp_timer_if.timer tif
);
    import rcp_pkg::*;

    logic [POWER_UP_TIMER_BITS-1:0] cnt_q;
    logic busy_q;
    wire last = cnt_q == POWER_UP_TIMER_BITS'(POWER_UP_TIMER_COUNTS - 1);

    // ----------------------------------------------------------------
    // Counter held at zero while restart is high
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk_i) begin
        if (!nrst_i) begin
            cnt_q <= '0;
            busy_q <= 1'b1;
        end else if (tif.restart) begin
            cnt_q <= '0;
            busy_q <= 1'b1;
        end else if (busy_q && tif.tick) begin
            cnt_q <= cnt_q + POWER_UP_TIMER_BITS'(1);
            busy_q <= !last;
        end
    end

    assign tif.busy = busy_q;

endmodule // rcp_pwrup_timer

// ===== design/rcp_reset_ctrl.sv
// Reset source handling, reset-cause recording and power-up timing
//
// Implementation choices: the APB slave port and the address map.
`timescale 1ns/10ps
module rcp_reset_ctrl
    import rcp_pkg::*;
#(
    parameter int unsigned RC_TICK_CYCLES_P = rcp_pkg::RC_TICK_CYCLES
) (
    input wire logic core_clk_i,
    input wire logic nrst_i,
    // APB slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [3:0] pstrb_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // Pins and analog detectors
    input wire logic master_clear_n_i,
    output logic master_clear_n_o,
    output logic master_clear_oe_o,
    input wire logic por_detect_i,
    input wire logic brownout_detect_i,
    input wire logic regulator_enable_pin_i,
    // Configuration words and shadows
    input wire logic [rcp_pkg::CFG_W-1:0] cfg_word_i,
    input wire logic [rcp_pkg::CFG_W-1:0] cfg_shadow_i,
    // Core events
    input wire logic reset_instr_i,
    input wire logic sleep_instr_i,
    input wire logic watchdog_clear_instr_i,
    input wire logic watchdog_timeout_i,
    input wire logic idle_or_sleep_i,
    // Outputs
    output logic sys_reset_o,
    output logic interrupt_priority_enable_o,
    output logic power_up_timer_busy_o,
    output logic irq_o
);
    import rcp_pkg::*;

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    localparam int unsigned SYNC_W = 4;
    localparam logic [SYNC_W-1:0] SYNC_RST = 4'h1;
    logic [SYNC_W-1:0] pins_raw;
    logic [SYNC_W-1:0] pins_s;
    assign pins_raw = {regulator_enable_pin_i, brownout_detect_i, por_detect_i,
                       master_clear_n_i};

    genvar gi;
    generate
        for (gi = 0; gi < SYNC_W; gi++) begin : g_sync
            logic meta_q;
            logic sync_q;
            always_ff @(posedge core_clk_i) begin
                if (!nrst_i) begin
                    meta_q <= SYNC_RST[gi];
                    sync_q <= SYNC_RST[gi];
                end else begin
                    meta_q <= pins_raw[gi];
                    sync_q <= meta_q;
                end
            end
            assign pins_s[gi] = sync_q;
        end
    endgenerate

    wire master_clear_n_n_s = pins_s[0];
    wire por_s = pins_s[1];
    wire bor_raw_s = pins_s[2];
    wire regulator_on_s = pins_s[3];

    // ----------------------------------------------------------------
    // Master-clear filtering
    // ----------------------------------------------------------------
    logic master_clear_n_n_f;
    rcp_glitch_filter u_filter (
        .core_clk_i(core_clk_i),
        .nrst_i(nrst_i),
        .level_i(master_clear_n_n_s),
        .level_o(master_clear_n_n_f)
    );

    assign master_clear_n_o = 1'b1;
    assign master_clear_oe_o = 1'b0;

    // ----------------------------------------------------------------
    // Source levels and edges
    // ----------------------------------------------------------------
    logic por_q;
    logic bor_q;
    logic master_clear_n_n_q;
    logic mismatch_q;

    wire bor_s = bor_raw_s && regulator_on_s;
    wire mismatch = cfg_word_i != ~cfg_shadow_i;

    wire por_evt = por_s && !por_q;
    wire bor_evt = bor_s && !bor_q;
    wire master_clear_n_evt = !master_clear_n_n_f && master_clear_n_n_q;
    wire cm_evt = mismatch && !mismatch_q;
    wire ri_evt = reset_instr_i;
    wire wdt_evt = watchdog_timeout_i;

    always_ff @(posedge core_clk_i) begin
        if (!nrst_i) begin
            por_q <= 1'b0;
            bor_q <= 1'b0;
            master_clear_n_n_q <= 1'b1;
            mismatch_q <= 1'b0;
        end else begin
            por_q <= por_s;
            bor_q <= bor_s;
            master_clear_n_n_q <= master_clear_n_n_f;
            mismatch_q <= mismatch;
        end
    end

    // ----------------------------------------------------------------
    // Slow oscillator tick divider
    // ----------------------------------------------------------------
    logic [13:0] div_q;
    wire div_wrap = div_q == 14'(RC_TICK_CYCLES_P - 1);

    always_ff @(posedge core_clk_i) begin
        if (!nrst_i) begin
            div_q <= 14'h0000;
        end else if (div_wrap) begin
            div_q <= 14'h0000;
        end else begin
            div_q <= div_q + 14'h0001;
        end
    end

    // ----------------------------------------------------------------
    // Power-up timer
    // ----------------------------------------------------------------
    rcp_timer_if tif ();
    assign tif.tick = div_wrap;
    // restart while power-on or brown-out holds
    assign tif.restart = por_s || bor_s;

    rcp_pwrup_timer u_timer (
        .core_clk_i(core_clk_i),
        .nrst_i(nrst_i),
        .tif(tif.timer)
    );

    // ----------------------------------------------------------------
    // Pulse stretch for one-shot reset sources
    // ----------------------------------------------------------------
    logic [2:0] hold_q;
    wire pulse_src = cm_evt || ri_evt || wdt_evt;

    always_ff @(posedge core_clk_i) begin
        if (!nrst_i) begin
            hold_q <= 3'h0;
        end else if (pulse_src) begin
            hold_q <= 3'(RST_HOLD_CYCLES);
        end else if (hold_q != 3'h0) begin
            hold_q <= hold_q - 3'h1;
        end
    end

    // ----------------------------------------------------------------
    // Internal reset
    // ----------------------------------------------------------------
    logic sys_reset_q;
    wire reset_any = por_s || bor_s || !master_clear_n_n_f || mismatch || pulse_src
        || hold_q != 3'h0 || tif.busy;

    always_ff @(posedge core_clk_i) begin
        if (!nrst_i) begin
            sys_reset_q <= 1'b1;
        end else begin
            sys_reset_q <= reset_any;
        end
    end

    assign sys_reset_o = sys_reset_q;
    assign power_up_timer_busy_o = tif.busy;

    // ----------------------------------------------------------------
    // APB decode
    // ----------------------------------------------------------------
    wire setup = psel_i && !penable_i;
    wire access = psel_i && penable_i;
    wire sel_cause = paddr_i == OFS_RESET_CAUSE;
    wire sel_status = paddr_i == OFS_EVT_STATUS;
    wire sel_clear = paddr_i == OFS_EVT_CLEAR;
    wire sel_enable = paddr_i == OFS_EVT_ENABLE;
    wire addr_hit = sel_cause || sel_status || sel_clear || sel_enable;
    wire wr_lo = access && pwrite_i && pstrb_i[0];
    wire wr_cause = wr_lo && sel_cause;
    wire wr_clear = wr_lo && sel_clear;
    wire wr_enable = wr_lo && sel_enable;

    assign pready_o = 1'b1;
    assign pslverr_o = access && !addr_hit;

    // ----------------------------------------------------------------
    // Reset cause register
    // ----------------------------------------------------------------
    logic [7:0] cause_q;
    logic [7:0] cause_d;

    always_comb begin
        cause_d = cause_q;
        if (wr_cause) begin
            cause_d = (cause_q & ~RESET_CAUSE_SW_MASK) | (pwdata_i[7:0] & RESET_CAUSE_SW_MASK);
        end
        if (watchdog_clear_instr_i) begin
            cause_d[BIT_TO] = 1'b1;
            cause_d[BIT_PD] = 1'b1;
        end
        if (sleep_instr_i) begin
            cause_d[BIT_TO] = 1'b1;
            cause_d[BIT_PD] = 1'b0;
        end
        if (master_clear_n_evt && idle_or_sleep_i) begin
            cause_d[BIT_TO] = 1'b1;
            cause_d[BIT_PD] = 1'b0;
        end
        if (wdt_evt) begin
            cause_d[BIT_TO] = 1'b0;
        end
        if (ri_evt) begin
            cause_d[BIT_RI] = 1'b0;
        end
        if (cm_evt) begin
            cause_d[BIT_CM] = 1'b0;
        end
        if (bor_evt) begin
            cause_d[BIT_RI] = 1'b1;
            cause_d[BIT_TO] = 1'b1;
            cause_d[BIT_PD] = 1'b1;
            cause_d[BIT_BOR] = 1'b0;
        end
        if (por_evt) begin
            cause_d[BIT_RI] = 1'b1;
            cause_d[BIT_TO] = 1'b1;
            cause_d[BIT_PD] = 1'b1;
            cause_d[BIT_POR] = 1'b0;
            cause_d[BIT_BOR] = 1'b0;
        end
        if (!regulator_on_s) begin
            cause_d[BIT_BOR] = 1'b0;
        end
        cause_d[BIT_UNUSED] = 1'b0;
    end

    always_ff @(posedge core_clk_i) begin
        if (!nrst_i) begin
            cause_q <= RESET_CAUSE_RST;
        end else begin
            cause_q <= cause_d;
        end
    end

    assign interrupt_priority_enable_o = cause_q[BIT_INTERRUPT_PRIORITY_ENABLE];

    // ----------------------------------------------------------------
    // Event status, enable and interrupt
    // ----------------------------------------------------------------
    logic [EVT_W-1:0] evt_q;
    logic [EVT_W-1:0] evt_en_q;
    logic [EVT_W-1:0] evt_set;
    logic [EVT_W-1:0] evt_clr;

    assign evt_set = {wdt_evt, ri_evt, cm_evt, master_clear_n_evt, bor_evt, por_evt};
    assign evt_clr = wr_clear ? pwdata_i[EVT_W-1:0] : EVT_RST;

    // Set wins over a clear in the same cycle
    always_ff @(posedge core_clk_i) begin
        if (!nrst_i) begin
            evt_q <= EVT_RST;
            evt_en_q <= EVT_RST;
        end else begin
            evt_q <= (evt_q & ~evt_clr) | evt_set;
            if (wr_enable) begin
                evt_en_q <= pwdata_i[EVT_W-1:0];
            end
        end
    end

    assign irq_o = |(evt_q & evt_en_q);

    // ----------------------------------------------------------------
    // Read data, captured in the setup phase
    // ----------------------------------------------------------------
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;

    assign rdata_d = sel_cause ? {24'h000000, cause_q} :
                     sel_status ? {26'h0000000, evt_q} :
                     sel_enable ? {26'h0000000, evt_en_q} : 32'h00000000;

    always_ff @(posedge core_clk_i) begin
        if (!nrst_i) begin
            rdata_q <= 32'h00000000;
        end else if (setup && !pwrite_i) begin
            rdata_q <= rdata_d;
        end
    end

    assign prdata_o = rdata_q;

endmodule // rcp_reset_ctrl

// ===== test/rcp_reset_ctrl_asserts.sv
// Port-level checker for the reset-cause and power-up timer block
`timescale 1ns/10ps
module rcp_reset_ctrl_asserts #(
    parameter int unsigned RC_TICK_CYCLES_P = 4
) (
    input wire logic core_clk_i,
    input wire logic nrst_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [3:0] pstrb_i,
    input wire logic [31:0] prdata_o,
    input wire logic master_clear_n_o,
    input wire logic master_clear_oe_o,
    input wire logic por_detect_i,
    input wire logic brownout_detect_i,
    input wire logic regulator_enable_pin_i,
    input wire logic sys_reset_o,
    input wire logic interrupt_priority_enable_o,
    input wire logic power_up_timer_busy_o,
    input wire logic irq_o
);
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    localparam int unsigned T_MIN = 2047 * RC_TICK_CYCLES_P;
    localparam int unsigned T_MAX = 2049 * RC_TICK_CYCLES_P + 8;
    logic [31:0] busy_cnt_q;
    logic [31:0] busy_cnt_d;
    wire logic restart = por_detect_i || (brownout_detect_i && regulator_enable_pin_i);
    wire logic rd_cause = psel_i && penable_i && !pwrite_i && (paddr_i == 8'h00);
    wire logic wr_cause = psel_i && penable_i && pwrite_i && (paddr_i == 8'h00) && pstrb_i[0];
    assign busy_cnt_d = (!power_up_timer_busy_o || restart) ? 32'h0 : busy_cnt_q + 32'h1;
    always_ff @(posedge core_clk_i) begin
        if (!nrst_i) begin
            busy_cnt_q <= 32'h0;
        end else begin
            busy_cnt_q <= busy_cnt_d;
        end
    end
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!nrst_i);
    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    AST_PIN_NEVER_DRIVEN: assert property (!master_clear_oe_o && master_clear_n_o)
        else $error("master-clear pin driven");
    AST_TIMER_HOLDS_RESET: assert property (power_up_timer_busy_o |=> sys_reset_o)
        else $error("reset released while timer busy");
    AST_TIMER_LENGTH: assert property ($fell(power_up_timer_busy_o) |->
        (busy_cnt_q >= T_MIN) && (busy_cnt_q <= T_MAX))
        else $error("power-up timer length wrong");
    AST_POR_STARTS_TIMER: assert property ($fell(por_detect_i) |->
        power_up_timer_busy_o [*6])
        else $error("timer not running after power-on");
    AST_POR_HOLDS_RESET: assert property (por_detect_i [*5] |=> sys_reset_o)
        else $error("power-on not holding reset");
    AST_BOR_RESTARTS: assert property (($rose(brownout_detect_i) && regulator_enable_pin_i)
        |-> ##[1:6] power_up_timer_busy_o)
        else $error("brown-out did not start timer");
    AST_RELEASE_AFTER_TIMER: assert property ($fell(sys_reset_o) |->
        !$past(power_up_timer_busy_o))
        else $error("reset fell with timer busy");
    AST_BIT6_ZERO: assert property (rd_cause |->
        (prdata_o[6] == 1'b0) && (prdata_o[31:8] == 24'h0))
        else $error("unused cause bits not zero");
    AST_PRIORITY_WRITE: assert property (wr_cause |=>
        interrupt_priority_enable_o == $past(pwdata_i[7]))
        else $error("priority enable not written");
    AST_BOR_FLAG_OFF: assert property (!regulator_enable_pin_i [*8] ##0 rd_cause |->
        prdata_o[0] == 1'b0)
        else $error("brown-out flag set with regulator off");
    COV_TIMER_DONE: cover property ($fell(power_up_timer_busy_o));
    COV_IRQ: cover property ($rose(irq_o));
    COV_READ_REG_OFF: cover property (rd_cause && !regulator_enable_pin_i);
endmodule // rcp_reset_ctrl_asserts

bind rcp_reset_ctrl rcp_reset_ctrl_asserts #(.RC_TICK_CYCLES_P(RC_TICK_CYCLES_P))
    u_rcp_reset_ctrl_asserts (.core_clk_i, .nrst_i, .psel_i, .penable_i, .pwrite_i,
    .paddr_i, .pwdata_i, .pstrb_i, .prdata_o, .master_clear_n_o, .master_clear_oe_o,
    .por_detect_i, .brownout_detect_i, .regulator_enable_pin_i, .sys_reset_o,
    .interrupt_priority_enable_o, .power_up_timer_busy_o, .irq_o);

// ===== test/rcp_supply_model.sv
// Model of the reset pin driver and supply monitor
`timescale 1ns/10ps
module rcp_supply_model (
    input wire logic core_clk_i,
    output logic por_detect_o,
    output logic brownout_detect_o,
    output logic regulator_enable_o,
    output logic master_clear_n_drive_n_o
);
    initial begin
        por_detect_o = 1'b0;
        brownout_detect_o = 1'b0;
        regulator_enable_o = 1'b1;
        master_clear_n_drive_n_o = 1'b1;
    end
    task automatic power_cycle(input int n);
        @(posedge core_clk_i);
        por_detect_o <= 1'b1;
        repeat (n) @(posedge core_clk_i);
        por_detect_o <= 1'b0;
    endtask
    task automatic supply_dip(input int n);
        @(posedge core_clk_i);
        brownout_detect_o <= 1'b1;
        repeat (n) @(posedge core_clk_i);
        brownout_detect_o <= 1'b0;
    endtask
    // pin held low, released to pull-up
    task automatic master_clear_n_hold(input int n);
        @(posedge core_clk_i);
        master_clear_n_drive_n_o <= 1'b0;
        repeat (n) @(posedge core_clk_i);
        master_clear_n_drive_n_o <= 1'b1;
    endtask
    task automatic master_clear_n_set(input logic v);
        @(posedge core_clk_i);
        master_clear_n_drive_n_o <= v;
    endtask
    task automatic regulator_set(input logic v);
        @(posedge core_clk_i);
        regulator_enable_o <= v;
    endtask
endmodule // rcp_supply_model

// ===== test/reset_cause_and_power_up_timer_tb_top.sv
// Testbench for the reset-cause and power-up timer block
`timescale 1ns/10ps
module reset_cause_and_power_up_timer_tb_top;
    import rcp_pkg::*;
    localparam int TICK = 4;
    localparam int TMR = 2048 * TICK;
    typedef struct packed {
        logic [1:0] op;
        logic [7:0] addr;
        logic [31:0] data;
        logic [31:0] exp;
        logic err;
    } rcp_row_t;
    logic core_clk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] evt = 4'h0;
    logic idle = 1'b0;
    logic [15:0] shadow = 16'hedcb;
    logic [3:0] strb = 4'hf;
    logic [15:0] cfg = 16'h1234;
    logic [31:0] prdata;
    logic pready, pslverr, master_clear_n_n_o, master_clear_n_oe, por, bor, reg_en, master_clear_n_drv_n;
    logic sys_rst, interrupt_priority_enable, busy, irq;
    int cyc = 0;
    int miscompares = 0;
    int cmp_count = 0;
    wire logic master_clear_n_pin = master_clear_n_oe ? master_clear_n_n_o : master_clear_n_drv_n;
    rcp_row_t rows [16] = '{
        '{2'h0, 8'h00, 32'hff, 32'h0, 1'h0}, '{2'h1, 8'h00, 32'h0, 32'hbf, 1'h0},
        '{2'h0, 8'h00, 32'h00, 32'h0, 1'h0}, '{2'h1, 8'h00, 32'h0, 32'h0c, 1'h0},
        '{2'h0, 8'h00, 32'h33, 32'h0, 1'h0}, '{2'h1, 8'h00, 32'h0, 32'h3f, 1'h0},
        '{2'h0, 8'h0c, 32'h3f, 32'h0, 1'h0}, '{2'h1, 8'h0c, 32'h0, 32'h3f, 1'h0},
        '{2'h1, 8'h08, 32'h0, 32'h00, 1'h0}, '{2'h0, 8'h10, 32'hff, 32'h0, 1'h1},
        '{2'h1, 8'h10, 32'h0, 32'h00, 1'h1}, '{2'h1, 8'h04, 32'h0, 32'h00, 1'h0},
        '{2'h2, 8'h00, 32'h1, 32'h2f, 1'h0}, '{2'h2, 8'h00, 32'h2, 32'h27, 1'h0},
        '{2'h2, 8'h00, 32'h4, 32'h2b, 1'h0}, '{2'h2, 8'h00, 32'h8, 32'h2f, 1'h0}};
    rcp_reset_ctrl #(.RC_TICK_CYCLES_P(TICK)) u_rcp_reset_ctrl (
        .core_clk_i(core_clk_i), .nrst_i(nrst_i), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(strb),
        .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
        .master_clear_n_i(master_clear_n_pin), .master_clear_n_o(master_clear_n_n_o),
        .master_clear_oe_o(master_clear_n_oe), .por_detect_i(por), .brownout_detect_i(bor),
        .regulator_enable_pin_i(reg_en), .cfg_word_i(cfg), .cfg_shadow_i(shadow),
        .reset_instr_i(evt[0]), .watchdog_timeout_i(evt[1]), .sleep_instr_i(evt[2]),
        .watchdog_clear_instr_i(evt[3]), .idle_or_sleep_i(idle), .sys_reset_o(sys_rst),
        .interrupt_priority_enable_o(interrupt_priority_enable), .power_up_timer_busy_o(busy), .irq_o(irq));
    rcp_supply_model u_rcp_supply_model (.core_clk_i(core_clk_i), .por_detect_o(por),
        .brownout_detect_o(bor), .regulator_enable_o(reg_en), .master_clear_n_drive_n_o(master_clear_n_drv_n));
    always #2 core_clk_i = ~core_clk_i;
    always @(posedge core_clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            miscompares++;
            report_and_stop();
        end
    end
    task automatic report_and_stop();
        $display("compares %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] rd, output logic err);
        @(posedge core_clk_i);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk_i);
        penable <= 1'b1;
        do @(posedge core_clk_i); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic run_row(input rcp_row_t r);
        logic [31:0] d;
        logic e;
        if (r.op == 2'h2) begin
            @(posedge core_clk_i);
            evt <= r.data[3:0];
            @(posedge core_clk_i);
            evt <= 4'h0;
            repeat (3) @(posedge core_clk_i);
        end
        apb(r.op == 2'h0, r.addr, r.data, d, e);
        if (r.op != 2'h0) chk("read data", r.exp, d);
        chk("slave error", {31'h0, r.err}, {31'h0, e});
    endtask
    task automatic wait_release(input int lo, input int hi);
        int n;
        n = 0;
        while (sys_rst !== 1'b0) begin
            @(posedge core_clk_i);
            n++;
        end
        chk("release delay", 32'h1, {31'h0, (n >= lo) && (n <= hi)});
    endtask
    task automatic chk_seen(input string name, input logic exp, input int n);
        logic seen;
        seen = 1'b0;
        repeat (n) begin
            @(posedge core_clk_i);
            seen = seen | (sys_rst === 1'b1);
        end
        chk(name, {31'h0, exp}, {31'h0, seen});
    endtask
    initial begin
        logic [31:0] d;
        logic e;
        repeat (6) @(posedge core_clk_i);
        nrst_i <= 1'b1;
        #1;
        chk("reset held", 32'h1, {31'h0, sys_rst});
        chk("timer busy", 32'h1, {31'h0, busy});
        run_row('{2'h1, 8'h00, 32'h0, 32'h3c, 1'h0});
        wait_release(TMR - TICK - 8, TMR + TICK + 16);
        $display("test power-up done");
        foreach (rows[i]) run_row(rows[i]);
        chk("irq raised", 32'h1, {31'h0, irq});
        apb(1'b1, 8'h08, 32'h3f, d, e);
        repeat (2) @(posedge core_clk_i);
        chk("irq cleared", 32'h0, {31'h0, irq});
        apb(1'b1, 8'h0c, 32'h0, d, e);
        run_row('{2'h2, 8'h04, 32'h1, 32'h10, 1'h0});
        chk("irq masked", 32'h0, {31'h0, irq});
        $display("test registers and events done");
        @(posedge core_clk_i);
        shadow <= 16'h0000;
        chk_seen("mismatch reset", 1'b1, 12);
        shadow <= 16'hffff;
        cfg <= 16'h0000;
        run_row('{2'h1, 8'h00, 32'h0, 32'h0f, 1'h0});
        strb <= 4'h0;
        apb(1'b1, 8'h00, 32'h80, d, e);
        strb <= 4'hf;
        @(posedge core_clk_i);
        chk("strobe ignored", 32'h0, {31'h0, interrupt_priority_enable});
        idle <= 1'b1;
        u_rcp_supply_model.master_clear_n_hold(10);
        chk_seen("short pulse ignored", 1'b0, 80);
        u_rcp_supply_model.master_clear_n_hold(100);
        run_row('{2'h1, 8'h00, 32'h0, 32'h0b, 1'h0});
        idle <= 1'b0;
        $display("test mismatch and pin done");
        apb(1'b1, 8'h00, 32'h33, d, e);
        u_rcp_supply_model.supply_dip(20);
        run_row('{2'h1, 8'h00, 32'h0, 32'h3e, 1'h0});
        repeat (4000) @(posedge core_clk_i);
        chk("timer still busy", 32'h1, {31'h0, busy});
        u_rcp_supply_model.supply_dip(20);
        wait_release(TMR - TICK, TMR + TICK + 16);
        u_rcp_supply_model.regulator_set(1'b0);
        apb(1'b1, 8'h00, 32'h33, d, e);
        u_rcp_supply_model.supply_dip(20);
        chk_seen("no brown-out reset", 1'b0, 10);
        run_row('{2'h1, 8'h00, 32'h0, 32'h3e, 1'h0});
        $display("test brown-out done");
        u_rcp_supply_model.master_clear_n_set(1'b0);
        u_rcp_supply_model.power_cycle(20);
        run_row('{2'h1, 8'h00, 32'h0, 32'h3c, 1'h0});
        repeat (TMR + 100) @(posedge core_clk_i);
        chk("timer expired", 32'h0, {31'h0, busy});
        chk("pin holds reset", 32'h1, {31'h0, sys_rst});
        u_rcp_supply_model.master_clear_n_set(1'b1);
        wait_release(0, 70);
        $display("test power-on done");
        report_and_stop();
    end
endmodule // reset_cause_and_power_up_timer_tb_top
